// >>> hw/cmpc_top.sv
// Control and status logic around an analog voltage comparator.
// Assumes an APB master, an analog comparator and a converter outside.
//
// Notes on behaviour
// (R01) The result is high when the chosen positive input exceeds the negative.
// (R02) Without the converter path the pair field picks the two pins.
// (R03) With the converter path the channel field picks the negative input.
// (R04) Mux bit clear or converter on means a pin drives the negative input.
// (R05) Writing one to bit 7 of register A powers the comparator off.
// (R06) Software clears the interrupt enable before changing power-off.
// (R07) Bit 6 of register A puts the bandgap on the positive input.
// (R08) The result is synchronized to the clock before it is read in bit 5.
// (R09) An output change matching the event mode sets the flag in bit 4.
// (R10) The flag clears on vector entry or on a written one, not on zero.
// (R11) The interrupt is requested only with flag, enable and global enable.
// (R12) Mode 00 is toggle, 01 reserved, 10 falling and 11 rising edge.
// (R13) Software disables the interrupt before changing the event mode.
// (R14) Bit 7 of register B switches hysteresis on.
// (R15) Bit 6 of register B picks the small or the large hysteresis level.
// (R16) Bits 2 to 0 of register B hold the input-pair select field.
// (R17) Events come from comparing the result with its previous value.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`default_nettype none
`include "cmpc_params.svh"

module cmpc_top
  import cmpc_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // Clock, reset and enable.
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic                    clkEn,
  // APB slave.
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [`CMPC_DATA_W-1:0] pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [`CMPC_DATA_W-1:0] prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Comparator, converter and interrupt side.
  input  wire logic                    compareRaw,
  input  wire logic                    converterEnable,
  input  wire logic [`CMPC_CHAN_W-1:0] converterChannelSelect,
  input  wire logic                    globalIrqEnable,
  input  wire logic                    irqVectorAck,
  // Analog controls.
  output logic                         comparatorPowerOff,
  output cmpc_pos_t                    positiveSelect,
  output cmpc_neg_t                    negativeSelect,
  output logic      [`CMPC_CHAN_W-1:0] negativeChannel,
  output logic                         hysteresisEnable,
  output logic                         hysteresisLevel,
  // Interrupt request.
  output logic                         compareIrq
);

  cmpc_state_t stateReg;
  cmpc_state_t stateNext;

  logic                    syncResult;
  logic                    resultNow;
  logic                    eventHit;
  logic                    setupCyc;
  logic                    hitA;
  logic                    hitB;
  logic                    wrA;
  logic                    wrB;
  logic [`CMPC_DATA_W-1:0] readA;
  logic [`CMPC_DATA_W-1:0] readB;

  // Brings the comparator output into the clock domain.
  cmpc_sync #(
    .STAGES (`CMPC_SYNC_STAGES)
  ) uSync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .asyncIn (compareRaw),
    .syncOut (syncResult)
  );

  // A powered-off comparator reads as low.
  assign resultNow = syncResult & ~stateReg.powerOff; // R08 R01

  // Event detection against the previous result.
  always_comb begin
    unique case (stateReg.mode) // R12
      CMPC_MODE_TOGGLE: begin
        eventHit = resultNow ^ stateReg.prevResult; // R17
      end
      CMPC_MODE_RSVD: begin
        eventHit = 1'b0;
      end
      CMPC_MODE_FALL: begin
        eventHit = ~resultNow & stateReg.prevResult; // R17
      end
      CMPC_MODE_RISE: begin
        eventHit = resultNow & ~stateReg.prevResult; // R17
      end
    endcase
  end

  // Register decode.
  assign setupCyc = psel & ~penable;
  assign hitA     = (paddr == `CMPC_OFS_CTRLA);
  assign hitB     = (paddr == `CMPC_OFS_CTRLB);
  assign wrA = psel & penable & stateReg.pready & pwrite & hitA & pstrb[0];
  assign wrB = psel & penable & stateReg.pready & pwrite & hitB & pstrb[0];

  always_comb begin
    readA                  = `CMPC_RST_WORD;
    readA[`CMPC_A_OFF]     = stateReg.powerOff;
    readA[`CMPC_A_BG]      = stateReg.bandgap;
    readA[`CMPC_A_RES]     = resultNow; // R08
    readA[`CMPC_A_FLAG]    = stateReg.flag;
    readA[`CMPC_A_IE]      = stateReg.irqEn;
    readA[`CMPC_A_MUX]     = stateReg.muxEn;
    readA[`CMPC_A_MODE_HI:`CMPC_A_MODE_LO] = stateReg.mode;
    readB                  = `CMPC_RST_WORD;
    readB[`CMPC_B_HYS]     = stateReg.hysEn;
    readB[`CMPC_B_LVL]     = stateReg.hysLvl;
    readB[`CMPC_B_PAIR_HI:`CMPC_B_PAIR_LO] = stateReg.pair;
  end

  // Next state.
  always_comb begin
    stateNext            = stateReg;
    stateNext.prevResult = resultNow; // R17
    // Answer in the access cycle that follows each setup cycle.
    stateNext.pready     = setupCyc;
    stateNext.pslverr    = setupCyc & ~(hitA | hitB);
    if (setupCyc && !pwrite && hitA) begin
      stateNext.prdata = readA;
    end else if (setupCyc && !pwrite && hitB) begin
      stateNext.prdata = readB;
    end else if (setupCyc) begin
      stateNext.prdata = `CMPC_RST_WORD;
    end
    if (wrA) begin
      stateNext.powerOff = pwdata[`CMPC_A_OFF]; // R05
      stateNext.bandgap  = pwdata[`CMPC_A_BG]; // R07
      stateNext.irqEn    = pwdata[`CMPC_A_IE];
      stateNext.muxEn    = pwdata[`CMPC_A_MUX];
      stateNext.mode = cmpc_mode_t'(
        pwdata[`CMPC_A_MODE_HI:`CMPC_A_MODE_LO]); // R12
    end
    if (wrB) begin
      stateNext.hysEn  = pwdata[`CMPC_B_HYS]; // R14
      stateNext.hysLvl = pwdata[`CMPC_B_LVL]; // R15
      stateNext.pair =
        pwdata[`CMPC_B_PAIR_HI:`CMPC_B_PAIR_LO]; // R16
    end
    // Clearing by a written one or by vector entry; an event wins.
    if ((wrA && pwdata[`CMPC_A_FLAG]) || irqVectorAck) begin
      stateNext.flag = 1'b0; // R10
    end
    if (eventHit) begin
      stateNext.flag = 1'b1; // R09
    end
    stateNext.irq = stateReg.flag & stateReg.irqEn
                  & globalIrqEnable; // R11
    // Positive input.
    if (stateReg.bandgap) begin
      stateNext.posSel = CMPC_POS_BANDGAP; // R07
    end else if (stateReg.muxEn && !converterEnable) begin
      if (stateReg.pair[2]) begin
        stateNext.posSel = CMPC_POS_PIN2; // R03
      end else if (stateReg.pair[1]) begin
        stateNext.posSel = CMPC_POS_PIN1; // R03
      end else begin
        stateNext.posSel = CMPC_POS_PIN0; // R03
      end
    end else begin
      unique case (stateReg.pair) // R02
        `CMPC_PAIR_P0N1, `CMPC_PAIR_P0N2: begin
          stateNext.posSel = CMPC_POS_PIN0;
        end
        `CMPC_PAIR_P1N0, `CMPC_PAIR_P1N2: begin
          stateNext.posSel = CMPC_POS_PIN1;
        end
        default: begin
          stateNext.posSel = CMPC_POS_PIN2;
        end
      endcase
    end
    // Negative input.
    if (stateReg.muxEn && !converterEnable) begin
      stateNext.negSel  = CMPC_NEG_CHANNEL; // R03
      stateNext.negChan = converterChannelSelect; // R03
    end else begin
      stateNext.negChan = `CMPC_RST_CHAN;
      unique case (stateReg.pair) // R02 R04
        `CMPC_PAIR_P0N1: begin
          stateNext.negSel = CMPC_NEG_PIN1;
        end
        `CMPC_PAIR_P0N2, `CMPC_PAIR_P1N2: begin
          stateNext.negSel = CMPC_NEG_PIN2;
        end
        `CMPC_PAIR_P1N0, `CMPC_PAIR_P2N0: begin
          stateNext.negSel = CMPC_NEG_PIN0;
        end
        default: begin
          stateNext.negSel = CMPC_NEG_PIN1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stateReg            <= '0;
      stateReg.posSel     <= CMPC_POS_PIN0;
      stateReg.negSel     <= CMPC_NEG_PIN1;
      stateReg.mode       <= CMPC_MODE_TOGGLE;
      stateReg.prdata     <= `CMPC_RST_WORD;
      stateReg.pair       <= `CMPC_RST_PAIR;
      stateReg.negChan    <= `CMPC_RST_CHAN;
      stateReg.powerOff   <= `CMPC_RST_BIT;
    end else if (clkEn) begin
      stateReg <= stateNext;
    end
  end

  // Outputs.
  assign prdata             = stateReg.prdata;
  assign pready             = stateReg.pready;
  assign pslverr            = stateReg.pslverr;
  assign comparatorPowerOff = stateReg.powerOff;
  assign positiveSelect     = stateReg.posSel;
  assign negativeSelect     = stateReg.negSel;
  assign negativeChannel    = stateReg.negChan;
  assign hysteresisEnable   = stateReg.hysEn;
  assign hysteresisLevel    = stateReg.hysLvl;
  assign compareIrq         = stateReg.irq;

  // Checks.
  default clocking cbMain @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence seqRawHigh;
    (clkEn && !stateReg.powerOff && compareRaw) [*3];
  endsequence

  sequence seqWriteA;
    clkEn && wrA;
  endsequence

  sequence seqWriteB;
    clkEn && wrB;
  endsequence

  AST_RESULT_SYNC: assert property ( // R08
    seqRawHigh ##1 !stateReg.powerOff |-> resultNow)
    else $error("Result not high after synchronizer delay.");

  AST_POWER_OFF: assert property ( // R05
    seqWriteA ##0 pwdata[`CMPC_A_OFF] |=> comparatorPowerOff)
    else $error("Power-off write not taken.");

  AST_FLAG_W1C: assert property ( // R10
    seqWriteA ##0 (pwdata[`CMPC_A_FLAG] && !eventHit) |=> !stateReg.flag)
    else $error("Flag not cleared by written one.");

  AST_FLAG_W0: assert property ( // R10
    seqWriteA ##0 (!pwdata[`CMPC_A_FLAG] && stateReg.flag
      && !irqVectorAck) |=> stateReg.flag)
    else $error("Flag lost on written zero.");

  AST_FLAG_ACK: assert property ( // R10
    (clkEn && irqVectorAck && !eventHit) |=> !stateReg.flag)
    else $error("Flag not cleared on vector entry.");

  AST_SET_WINS: assert property ( // R09
    (clkEn && eventHit) |=> stateReg.flag)
    else $error("Event did not set the flag.");

  AST_RSVD_MODE: assert property ( // R12
    (clkEn && stateReg.mode == CMPC_MODE_RSVD && !stateReg.flag)
      |=> !stateReg.flag)
    else $error("Reserved mode raised the flag.");

  AST_RISE_EDGE: assert property ( // R17
    (clkEn && stateReg.mode == CMPC_MODE_RISE && resultNow
      && !stateReg.prevResult) |=> stateReg.flag)
    else $error("Rising edge missed.");

  AST_IRQ_REQ: assert property ( // R11
    clkEn |=> compareIrq == $past(stateReg.flag && stateReg.irqEn
      && globalIrqEnable))
    else $error("Interrupt request does not follow its terms.");

  AST_NEG_PIN: assert property ( // R04
    (clkEn && (!stateReg.muxEn || converterEnable))
      |=> negativeSelect != CMPC_NEG_CHANNEL)
    else $error("Converter channel used while not allowed.");

  AST_BANDGAP: assert property ( // R07
    (clkEn && stateReg.bandgap) |=> positiveSelect == CMPC_POS_BANDGAP)
    else $error("Bandgap not on positive input.");

  AST_APB_ANSWER: assert property (
    (clkEn && setupCyc) |=> pready)
    else $error("No answer after setup cycle.");

  AST_POWER_ON: assert property ( // R05
    seqWriteA ##0 !pwdata[`CMPC_A_OFF] |=> !comparatorPowerOff)
    else $error("Power-on write not taken.");

  AST_TOGGLE_EDGE: assert property ( // R12
    (clkEn && stateReg.mode == CMPC_MODE_TOGGLE
      && resultNow != stateReg.prevResult) |=> stateReg.flag)
    else $error("Output toggle missed.");

  AST_FALL_EDGE: assert property ( // R17
    (clkEn && stateReg.mode == CMPC_MODE_FALL && !resultNow
      && stateReg.prevResult) |=> stateReg.flag)
    else $error("Falling edge missed.");

  AST_HYS_ENABLE: assert property ( // R14
    seqWriteB |=> hysteresisEnable == $past(pwdata[`CMPC_B_HYS]))
    else $error("Hysteresis enable not taken.");

  AST_HYS_LEVEL: assert property ( // R15
    seqWriteB |=> hysteresisLevel == $past(pwdata[`CMPC_B_LVL]))
    else $error("Hysteresis level not taken.");

  AST_PAIR_FIELD: assert property ( // R16
    seqWriteB |=> stateReg.pair
      == $past(pwdata[`CMPC_B_PAIR_HI:`CMPC_B_PAIR_LO]))
    else $error("Pair field not taken.");

  AST_CHANNEL: assert property ( // R03
    (clkEn && stateReg.muxEn && !converterEnable)
      |=> negativeSelect == CMPC_NEG_CHANNEL
      && negativeChannel == $past(converterChannelSelect))
    else $error("Converter channel not on negative input.");

  AST_PAIR_P1N0: assert property ( // R02
    (clkEn && !stateReg.bandgap && !stateReg.muxEn
      && stateReg.pair == `CMPC_PAIR_P1N0)
      |=> positiveSelect == CMPC_POS_PIN1
      && negativeSelect == CMPC_NEG_PIN0)
    else $error("Pair 010 does not pick pin 1 over pin 0.");

endmodule : cmpc_top

`default_nettype wire

// >>> hw/cmpc_params.svh
// Constants for the comparator control block.
// Assumes inclusion by the package and the design files.
`ifndef CMPC_PARAMS_SVH
`define CMPC_PARAMS_SVH

`define CMPC_DATA_W     32
`define CMPC_CHAN_W     6
`define CMPC_PAIR_W     3
`define CMPC_SYNC_STAGES 2
`define CMPC_OFS_CTRLA  4'h0
`define CMPC_OFS_CTRLB  4'h4
`define CMPC_A_OFF      7
`define CMPC_A_BG       6
`define CMPC_A_RES      5
`define CMPC_A_FLAG     4
`define CMPC_A_IE       3
`define CMPC_A_MUX      2
`define CMPC_A_MODE_HI  1
`define CMPC_A_MODE_LO  0
`define CMPC_B_HYS      7
`define CMPC_B_LVL      6
`define CMPC_B_PAIR_HI  2
`define CMPC_B_PAIR_LO  0
`define CMPC_PAIR_P0N1  3'h0
`define CMPC_PAIR_P0N2  3'h1
`define CMPC_PAIR_P1N0  3'h2
`define CMPC_PAIR_P1N2  3'h3
`define CMPC_PAIR_P2N0  3'h4
`define CMPC_RST_BIT    1'h0
`define CMPC_RST_PAIR   3'h0
`define CMPC_RST_CHAN   6'h00
`define CMPC_RST_WORD   32'h0000_0000

`endif

// >>> hw/cmpc_pkg.sv
// Types shared by the comparator control block.
// Assumes the constants header is on the include path.
`default_nettype none
`include "cmpc_params.svh"

package cmpc_pkg;

  typedef enum logic [1:0] {
    CMPC_MODE_TOGGLE = 2'b00,
    CMPC_MODE_RSVD   = 2'b01,
    CMPC_MODE_FALL   = 2'b10,
    CMPC_MODE_RISE   = 2'b11
  } cmpc_mode_t;

  typedef enum logic [1:0] {
    CMPC_POS_PIN0    = 2'b00,
    CMPC_POS_PIN1    = 2'b01,
    CMPC_POS_PIN2    = 2'b10,
    CMPC_POS_BANDGAP = 2'b11
  } cmpc_pos_t;

  typedef enum logic [1:0] {
    CMPC_NEG_PIN0    = 2'b00,
    CMPC_NEG_PIN1    = 2'b01,
    CMPC_NEG_PIN2    = 2'b10,
    CMPC_NEG_CHANNEL = 2'b11
  } cmpc_neg_t;

  typedef struct packed {
    logic                     powerOff;
    logic                     bandgap;
    logic                     flag;
    logic                     irqEn;
    logic                     muxEn;
    cmpc_mode_t               mode;
    logic                     hysEn;
    logic                     hysLvl;
    logic [`CMPC_PAIR_W-1:0]  pair;
    logic                     prevResult;
    logic [`CMPC_DATA_W-1:0]  prdata;
    logic                     pready;
    logic                     pslverr;
    cmpc_pos_t                posSel;
    cmpc_neg_t                negSel;
    logic [`CMPC_CHAN_W-1:0]  negChan;
    logic                     irq;
  } cmpc_state_t;

endpackage : cmpc_pkg

`default_nettype wire

// >>> hw/cmpc_sync.sv
// Flip-flop chain that brings an asynchronous level into clk_sys.
// Assumes the input changes freely with respect to clk_sys.
`default_nettype none
`include "cmpc_params.svh"

module cmpc_sync #(
  parameter int STAGES = `CMPC_SYNC_STAGES
) (
  // Clock, reset and enable.
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic clkEn,
  // Level in and out.
  input  wire logic asyncIn,
  output logic      syncOut
);

  typedef struct packed {
    logic [STAGES-1:0] chain;
  } cmpc_sync_state_t;

  cmpc_sync_state_t stateReg;
  cmpc_sync_state_t stateNext;

  // Each stage reads only the stage before it.
  always_comb begin
    stateNext       = stateReg;
    stateNext.chain = {stateReg.chain[STAGES-2:0], asyncIn};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stateReg <= '0;
    end else if (clkEn) begin
      stateReg <= stateNext;
    end
  end

  assign syncOut = stateReg.chain[STAGES-1];

endmodule : cmpc_sync

`default_nettype wire

// >>> test/cmpc_analog_model.sv
// Behavioural model of the analog pins, the converter channels and
// the comparator. Assumes the selects come from the comparator block.
`default_nettype none

module cmpc_analog_model
  import cmpc_pkg::*;
(
  // Selects from the control block.
  input  wire cmpc_pos_t   positiveSelect,
  input  wire cmpc_neg_t   negativeSelect,
  input  wire logic [5:0]  negativeChannel,
  input  wire logic        comparatorPowerOff,
  // Comparison result.
  output logic             compareRaw
);
  timeunit 1ns;
  timeprecision 1ps;

  int pinMv [3] = '{100, 500, 300};
  int chanMv [11] = '{50, 150, 250, 350, 450, 550, 650, 750, 850, 950, 990};
  int posMv;
  int negMv;

  always_comb begin
    case (positiveSelect)
      CMPC_POS_PIN0: posMv = pinMv[0];
      CMPC_POS_PIN1: posMv = pinMv[1];
      CMPC_POS_PIN2: posMv = pinMv[2];
      default:       posMv = 1100;
    endcase
    case (negativeSelect)
      CMPC_NEG_PIN0: negMv = pinMv[0];
      CMPC_NEG_PIN1: negMv = pinMv[1];
      CMPC_NEG_PIN2: negMv = pinMv[2];
      default:       negMv = chanMv[negativeChannel % 11];
    endcase
    compareRaw = !comparatorPowerOff && (posMv > negMv);
  end
endmodule : cmpc_analog_model

`default_nettype wire

// >>> test/cmpc_top_bench.sv
// Self-checking bench for the comparator control block.
// Assumes the analog model stands on the comparator side.
`default_nettype none

module cmpc_top_bench
  import cmpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 0, sys_rst = 1, clkEn = 1;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [3:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, compareRaw, converterEnable = 0;
  logic [5:0]  converterChannelSelect = 0, negativeChannel;
  logic        globalIrqEnable = 0, irqVectorAck = 0;
  logic        comparatorPowerOff, hysteresisEnable, hysteresisLevel;
  logic        compareIrq;
  cmpc_pos_t   positiveSelect;
  cmpc_neg_t   negativeSelect;
  int          failures = 0, checks = 0, cycles = 0;
  int          seed = 32'h424fc745;
  int          posT [8] = '{0, 0, 1, 1, 2, 2, 2, 2};
  int          negT [8] = '{1, 2, 0, 2, 0, 1, 1, 1};
  logic [33:0] expQ [$];
  logic [33:0] expNote;
  logic [7:0]  regA = 0;
  logic [1:0]  hys;
  logic [5:0]  chan;

  always #5 clk_sys = ~clk_sys;

  cmpc_top i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compareRaw(compareRaw),
    .converterEnable(converterEnable),
    .converterChannelSelect(converterChannelSelect),
    .globalIrqEnable(globalIrqEnable), .irqVectorAck(irqVectorAck),
    .comparatorPowerOff(comparatorPowerOff),
    .positiveSelect(positiveSelect), .negativeSelect(negativeSelect),
    .negativeChannel(negativeChannel),
    .hysteresisEnable(hysteresisEnable),
    .hysteresisLevel(hysteresisLevel), .compareIrq(compareIrq));

  cmpc_analog_model i_model (.positiveSelect(positiveSelect),
    .negativeSelect(negativeSelect), .negativeChannel(negativeChannel),
    .comparatorPowerOff(comparatorPowerOff), .compareRaw(compareRaw));

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Notes the expected answer, then runs one APB transfer.
  task automatic apb(logic wr, logic [3:0] a, logic [31:0] d, logic err);
    expQ.push_back({!wr, err, wr ? 32'h0 : d});
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wr ? d : 32'h0;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setA(logic [7:0] d);
    regA = d & 8'hEF;
    apb(1'b1, 4'h0, {24'h0, d}, 1'b0);
  endtask : setA

  task automatic rdA(logic res, logic flag);
    apb(1'b0, 4'h0, {24'h0, regA[7:6], res, flag, regA[3:0]}, 1'b0);
  endtask : rdA

  task automatic level(logic hi);
    @(posedge clk_sys);
    i_model.pinMv[0] <= hi ? 900 : 100;
    repeat (6) @(posedge clk_sys);
  endtask : level

  // Watches the bus and compares each answer with the oldest note.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      stop_test();
    end
    if (psel && penable && pready) begin
      expNote = expQ.pop_front();
      cmp("pslverr", {31'h0, expNote[32]}, {31'h0, pslverr});
      if (expNote[33])
        cmp("prdata", expNote[31:0], prdata);
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdA(1'b0, 1'b0);
    apb(1'b0, 4'h4, 32'h0, 1'b0);
    cmp("negativeSelect", 32'h1, {30'h0, negativeSelect});
    for (int p = 0; p < 8; p++) begin
      hys = 2'($random(seed));
      apb(1'b1, 4'h4, {24'h0, hys, 3'h0, 3'(p)}, 1'b0);
      apb(1'b0, 4'h4, {24'h0, hys, 3'h0, 3'(p)}, 1'b0);
      cmp("positiveSelect", 32'(posT[p]), {30'h0, positiveSelect});
      cmp("negativeSelect", 32'(negT[p]), {30'h0, negativeSelect});
      cmp("hysteresis", {30'h0, hys},
          {30'h0, hysteresisEnable, hysteresisLevel});
    end
    for (int q = 0; q < 3; q++) begin
      converterEnable <= 1'b0;
      chan = 6'(($random(seed) & 32'h7FFFFFFF) % 11);
      converterChannelSelect <= chan;
      apb(1'b1, 4'h4, 32'(2 * q), 1'b0);
      setA(8'h04);
      repeat (3) @(posedge clk_sys);
      cmp("positiveSelect", 32'(q), {30'h0, positiveSelect});
      cmp("negativeSelect", 32'h3, {30'h0, negativeSelect});
      cmp("negativeChannel", {26'h0, chan}, {26'h0, negativeChannel});
      converterEnable <= 1'b1;
      repeat (3) @(posedge clk_sys);
      cmp("negativeSelect", 32'(negT[2 * q]),
          {30'h0, negativeSelect});
    end
    apb(1'b1, 4'h4, 32'h0, 1'b0);
    setA(8'h40);
    repeat (3) @(posedge clk_sys);
    cmp("positiveSelect", 32'h3, {30'h0, positiveSelect});
    setA(8'h00);
    for (int m = 0; m < 4; m++) begin
      level(1'b0);
      setA(8'h10 | 8'(m));
      level(1'b1);
      rdA(1'b1, m == 0 || m == 3);
      setA(8'h10 | 8'(m));
      level(1'b0);
      rdA(1'b0, m == 0 || m == 2);
    end
    setA(8'h13);
    level(1'b1);
    setA(8'h03);
    rdA(1'b1, 1'b1);
    setA(8'h0B);
    clkEn           <= 1'b0;
    globalIrqEnable <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cmp("compareIrq", 32'h0, {31'h0, compareIrq});
    clkEn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cmp("compareIrq", 32'h1, {31'h0, compareIrq});
    globalIrqEnable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    cmp("compareIrq", 32'h0, {31'h0, compareIrq});
    globalIrqEnable <= 1'b1;
    irqVectorAck    <= 1'b1;
    @(posedge clk_sys);
    irqVectorAck <= 1'b0;
    repeat (3) @(posedge clk_sys);
    cmp("compareIrq", 32'h0, {31'h0, compareIrq});
    rdA(1'b1, 1'b0);
    setA(8'h03);
    setA(8'h83);
    repeat (4) @(posedge clk_sys);
    cmp("powerOff", 32'h1, {31'h0, comparatorPowerOff});
    rdA(1'b0, 1'b0);
    apb(1'b0, 4'h8, 32'h0, 1'b1);
    apb(1'b1, 4'h8, 32'hFF, 1'b1);
    rdA(1'b0, 1'b0);
    stop_test();
  end
endmodule : cmpc_top_bench

`default_nettype wire
